// file: common/lts_pkg.sv
// Notes on behaviour
// RQ1: 80: increment, skip if equal memory word
// RQ2: 81: increment, skip if not equal
// RQ3: 82: decrement, skip if equal memory word
// RQ4: 83: decrement, skip if not equal
// RQ5: result code from modified register sign
// RQ6: skip instructions never raise an interruption
// RQ7: 84/86: add increment, branch if at most limit
// RQ8: 85/87: add increment, branch if above limit
// RQ9: odd limit pair selector raises specification error
// RQ10: base 0 pc-relative signed, else base unsigned
// RQ11: no indexing or indirection on branch target
// RQ12: 93: descriptor counts word, pointer word
// RQ13: software puts descriptor on even-odd pair
// RQ14: negative count abandons push, next instruction
// RQ15: write counts, read pointer, store register
// RQ16: pointer plus one, 32-bit, written back
// RQ17: successful push skips next instruction
// RQ18: 8F: decrement, branch if non-zero
// RQ19: register 0-7 index, 8-F vector
// RQ20: comparisons are signed 32-bit
package lts_pkg;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_INC_SKIP_EQUAL = 8'h80;
  localparam logic [7:0] OP_INC_SKIP_UNEQUAL = 8'h81;
  localparam logic [7:0] OP_DEC_SKIP_EQUAL = 8'h82;
  localparam logic [7:0] OP_DEC_SKIP_UNEQUAL = 8'h83;
  localparam logic [7:0] OP_ADD_BRANCH_IF_AT_MOST_A = 8'h84;
  localparam logic [7:0] OP_ADD_BRANCH_IF_ABOVE_A = 8'h85;
  localparam logic [7:0] OP_ADD_BRANCH_IF_AT_MOST_X = 8'h86;
  localparam logic [7:0] OP_ADD_BRANCH_IF_ABOVE_X = 8'h87;
  localparam logic [7:0] OP_DEC_BRANCH_NONZERO = 8'h8F;
  localparam logic [7:0] OP_STACK_PUSH_OP = 8'h93;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_EA = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [1:0] BANK_ARITH = 2'h1;
  localparam logic [2:0] BANK_INDEX = 3'h4;
  localparam logic [2:0] BANK_VECTOR = 3'h5;
  localparam logic [1:0] BANK_BASE = 2'h3;
  // ==========================================================
  // fields and reset values
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_SPEC_BIT = 4;
  localparam int STAT_ABANDON_BIT = 5;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] WORD_ONE = 32'h0000_0001;
  localparam logic [23:0] PC_RESET = 24'h00_0000;
  localparam logic [23:0] PC_STEP = 24'h00_0001;
  localparam logic [23:0] PC_SKIP = 24'h00_0002;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [2:0] RC_RESET = 3'h0;
  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] r;
    logic [3:0] t;
    logic [3:0] m;
    logic [11:0] n;
  } lts_instr_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [31:0] wdata;
  } lts_mem_cmd_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } lts_mem_resp_t;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_EXEC = 9'h002,
    S_OPRD = 9'h004,
    S_CNTRD = 9'h008,
    S_CNTWR = 9'h010,
    S_PTRRD = 9'h020,
    S_DATWR = 9'h040,
    S_PTRWR = 9'h080,
    S_SPARE = 9'h100
  } lts_state_t;
  // ==========================================================
  // functions
  function automatic logic [2:0] lts_rcode(input logic [31:0] v);
    lts_rcode = {v[31], !v[31] && (v != WORD_ZERO), v == WORD_ZERO};
  endfunction
  function automatic logic [31:0] lts_be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      lts_be_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
endpackage

// file: rtl/lts_exec_unit.sv
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module lts_exec_unit (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output lts_pkg::lts_mem_cmd_t mem_cmd,
  input wire lts_pkg::lts_mem_resp_t mem_resp,
  output logic spec_error,
  output logic [2:0] result_code
);
  import lts_pkg::*;

  lts_state_t st;
  lts_instr_t instr;
  logic [23:0] ea;
  logic [23:0] pc;
  logic [31:0] tmp;
  logic abandon;
  logic [31:0] arith [16];
  logic [31:0] xr [8];
  logic [31:0] vr [8];
  logic [31:0] br [16];

  // ==========================================================
  // helpers
  function automatic logic [31:0] xvr_read(input logic [3:0] sel);
    xvr_read = sel[3] ? vr[sel[2:0]] : xr[sel[2:0]]; // RQ19
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = WORD_ZERO;
    if (a[7:6] == BANK_ARITH)
      read_word = arith[a[5:2]];
    else if (a[7:5] == BANK_INDEX)
      read_word = xr[a[4:2]];
    else if (a[7:5] == BANK_VECTOR)
      read_word = vr[a[4:2]];
    else if (a[7:6] == BANK_BASE)
      read_word = br[a[5:2]];
    else
      case (a)
        OFF_INSTR: read_word = instr;
        OFF_EA: read_word = {8'h00, ea};
        OFF_PC: read_word = {8'h00, pc};
        OFF_STATUS: read_word = {26'h0, abandon, spec_error, result_code, st != S_IDLE};
        default: read_word = WORD_ZERO;
      endcase
  endfunction

  logic is_limit;
  logic is_skip;
  logic [31:0] limit_cur;
  logic [31:0] limit_sum;
  logic [31:0] limit_max;
  logic limit_take;
  logic [23:0] beta;
  logic [15:0] next_wc;
  logic [15:0] next_sc;
  logic push_bad;
  logic wr_ok;

  assign is_skip = instr.opcode[7:2] == OP_INC_SKIP_EQUAL[7:2];
  assign is_limit = instr.opcode[7:2] == OP_ADD_BRANCH_IF_AT_MOST_A[7:2];
  assign limit_cur = instr.opcode[1] ? xvr_read(instr.r) : arith[instr.r];
  assign limit_sum = limit_cur + arith[instr.t];
  assign limit_max = arith[{instr.t[3:1], 1'b1}];
  // signed compare, above for odd opcodes
  assign limit_take = instr.opcode[0] ? ($signed(limit_sum) > $signed(limit_max)) : // RQ8 RQ20
                      ($signed(limit_sum) <= $signed(limit_max)); // RQ7
  // no index or indirection on the target
  assign beta = (instr.m == 4'h0) ? pc + {{12{instr.n[11]}}, instr.n} : // RQ10 RQ11
                br[instr.m][23:0] + {12'h000, instr.n};
  assign next_wc = mem_resp.rdata[31:16] + COUNT_ONE; // RQ12
  assign next_sc = mem_resp.rdata[15:0] - COUNT_ONE;
  assign push_bad = next_wc[15] || next_sc[15];
  assign wr_ok = avs_write && !avs_waitrequest && (st == S_IDLE);

  // ==========================================================
  // bus slave
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= WORD_ZERO;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= read_word(avs_address);
    end
  end

  // ==========================================================
  // flags
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spec_error <= 1'b0;
      abandon <= 1'b0;
    end
    else
    begin
      spec_error <= (st == S_EXEC && is_limit && instr.t[0]) || // RQ6 RQ9
                    (spec_error && !(wr_ok && avs_address == OFF_STATUS && avs_writedata[STAT_SPEC_BIT]));
      abandon <= (st == S_CNTRD && mem_resp.ack && push_bad) ||
                 (abandon && !(wr_ok && avs_address == OFF_STATUS && avs_writedata[STAT_ABANDON_BIT]));
    end
  end

  // ==========================================================
  // engine and register file
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= S_IDLE;
      instr <= '0;
      ea <= PC_RESET;
      pc <= PC_RESET;
      tmp <= WORD_ZERO;
      result_code <= RC_RESET;
      mem_cmd <= '0;
      for (int i = 0; i < 16; i++)
      begin
        arith[i] <= WORD_ZERO;
        br[i] <= WORD_ZERO;
      end
      for (int i = 0; i < 8; i++)
      begin
        xr[i] <= WORD_ZERO;
        vr[i] <= WORD_ZERO;
      end
    end
    else
    begin
      case (st)
        S_IDLE:
        begin
          if (wr_ok)
          begin
            if (avs_address[7:6] == BANK_ARITH)
              arith[avs_address[5:2]] <= lts_be_merge(arith[avs_address[5:2]], avs_writedata, avs_byteenable);
            else if (avs_address[7:5] == BANK_INDEX)
              xr[avs_address[4:2]] <= lts_be_merge(xr[avs_address[4:2]], avs_writedata, avs_byteenable);
            else if (avs_address[7:5] == BANK_VECTOR)
              vr[avs_address[4:2]] <= lts_be_merge(vr[avs_address[4:2]], avs_writedata, avs_byteenable);
            else if (avs_address[7:6] == BANK_BASE)
              br[avs_address[5:2]] <= lts_be_merge(br[avs_address[5:2]], avs_writedata, avs_byteenable);
            else if (avs_address == OFF_INSTR)
              instr <= lts_be_merge(instr, avs_writedata, avs_byteenable);
            else if (avs_address == OFF_EA)
              ea <= 24'(lts_be_merge({8'h00, ea}, avs_writedata, avs_byteenable));
            else if (avs_address == OFF_PC)
              pc <= 24'(lts_be_merge({8'h00, pc}, avs_writedata, avs_byteenable));
            else if (avs_address == OFF_CTRL && avs_byteenable[0] && avs_writedata[CTRL_START_BIT])
              st <= S_EXEC;
          end
        end
        S_EXEC:
        begin
          st <= S_IDLE;
          if (is_skip)
          begin
            // step the register and issue the compare word fetch in the same cycle
            tmp <= instr.opcode[1] ? arith[instr.r] - WORD_ONE : arith[instr.r] + WORD_ONE; // RQ1 RQ3
            arith[instr.r] <= instr.opcode[1] ? arith[instr.r] - WORD_ONE : arith[instr.r] + WORD_ONE; // RQ2 RQ4
            result_code <= lts_rcode(instr.opcode[1] ? arith[instr.r] - WORD_ONE : arith[instr.r] + WORD_ONE); // RQ5
            mem_cmd <= '{req: 1'b1, we: 1'b0, addr: ea, wdata: WORD_ZERO};
            st <= S_OPRD;
          end
          else if (is_limit)
          begin
            if (!instr.t[0])
            begin
              if (instr.opcode[1])
              begin
                if (instr.r[3])
                  vr[instr.r[2:0]] <= limit_sum; // RQ19
                else
                  xr[instr.r[2:0]] <= limit_sum;
              end
              else
                arith[instr.r] <= limit_sum;
              result_code <= lts_rcode(limit_sum); // RQ5
              pc <= limit_take ? beta : pc + PC_STEP; // RQ7 RQ8
            end
          end
          else if (instr.opcode == OP_DEC_BRANCH_NONZERO)
          begin
            if (instr.r[3])
              vr[instr.r[2:0]] <= xvr_read(instr.r) - WORD_ONE; // RQ18
            else
              xr[instr.r[2:0]] <= xvr_read(instr.r) - WORD_ONE;
            result_code <= lts_rcode(xvr_read(instr.r) - WORD_ONE);
            pc <= (xvr_read(instr.r) != WORD_ONE) ? ea : pc + PC_STEP;
          end
          else if (instr.opcode == OP_STACK_PUSH_OP)
          begin
            mem_cmd <= '{req: 1'b1, we: 1'b0, addr: ea, wdata: WORD_ZERO}; // RQ12
            st <= S_CNTRD;
          end
          else
            pc <= pc + PC_STEP;
        end
        S_OPRD:
        begin
          if (mem_resp.ack)
          begin
            // odd opcodes skip on inequality
            pc <= pc + (((tmp == mem_resp.rdata) != instr.opcode[0]) ? PC_SKIP : PC_STEP); // RQ1 RQ2 RQ3 RQ4
            mem_cmd <= '0;
            st <= S_IDLE;
          end
        end
        S_CNTRD:
        begin
          if (mem_resp.ack)
          begin
            if (push_bad)
            begin
              pc <= pc + PC_STEP; // RQ14
              mem_cmd <= '0;
              st <= S_IDLE;
            end
            else
            begin
              mem_cmd <= '{req: 1'b1, we: 1'b1, addr: ea, wdata: {next_wc, next_sc}}; // RQ15
              st <= S_CNTWR;
            end
          end
        end
        S_CNTWR:
        begin
          if (mem_resp.ack)
          begin
            mem_cmd <= '{req: 1'b1, we: 1'b0, addr: ea + PC_STEP, wdata: WORD_ZERO}; // RQ15
            st <= S_PTRRD;
          end
        end
        S_PTRRD:
        begin
          if (mem_resp.ack)
          begin
            tmp <= mem_resp.rdata;
            mem_cmd <= '{req: 1'b1, we: 1'b1, addr: mem_resp.rdata[23:0], wdata: arith[instr.r]}; // RQ15
            st <= S_DATWR;
          end
        end
        S_DATWR:
        begin
          if (mem_resp.ack)
          begin
            mem_cmd <= '{req: 1'b1, we: 1'b1, addr: ea + PC_STEP, wdata: tmp + WORD_ONE}; // RQ16
            st <= S_PTRWR;
          end
        end
        S_PTRWR:
        begin
          if (mem_resp.ack)
          begin
            pc <= pc + PC_SKIP; // RQ17
            mem_cmd <= '0;
            st <= S_IDLE;
          end
        end
        default:
        begin
          mem_cmd <= '0;
          st <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_exec(logic [7:0] op);
    st == S_EXEC && instr.opcode == op;
  endsequence
  sequence s_counts_ok;
    st == S_CNTRD && mem_resp.ack && !push_bad;
  endsequence

  property p_skip(logic [7:0] op, logic on_equal);
    st == S_OPRD && mem_resp.ack && instr.opcode == op
      |=> pc == $past(pc) + ((($past(tmp) == $past(mem_resp.rdata)) == on_equal) ? PC_SKIP : PC_STEP);
  endproperty

  a_inc_skip_eq: assert property (p_skip(OP_INC_SKIP_EQUAL, 1'b1)) else $error("inc skip equal pc wrong"); // RQ1
  a_inc_skip_ne: assert property (p_skip(OP_INC_SKIP_UNEQUAL, 1'b0)) else $error("inc skip unequal pc wrong"); // RQ2
  a_dec_skip_eq: assert property (p_skip(OP_DEC_SKIP_EQUAL, 1'b1)) else $error("dec skip equal pc wrong"); // RQ3
  a_dec_skip_ne: assert property (p_skip(OP_DEC_SKIP_UNEQUAL, 1'b0)) else $error("dec skip unequal pc wrong"); // RQ4
  a_inc_reg_step: assert property (s_exec(OP_INC_SKIP_EQUAL) |=> arith[instr.r] == $past(arith[instr.r]) + WORD_ONE ##1 // RQ1
    mem_cmd.req && !mem_cmd.we && mem_cmd.addr == ea) else $error("increment or operand fetch wrong");
  a_dec_reg_step: assert property (s_exec(OP_DEC_SKIP_UNEQUAL) |=> arith[instr.r] == $past(arith[instr.r]) - WORD_ONE) // RQ4
    else $error("decrement wrong");
  a_result_sign: assert property (st == S_EXEC && is_skip |=> result_code == {tmp[31], !tmp[31] && tmp != WORD_ZERO, // RQ5
    tmp == WORD_ZERO}) else $error("result code wrong");
  a_skip_no_int: assert property (st == S_EXEC && is_skip |=> !$rose(spec_error) && st != S_IDLE) // RQ6
    else $error("skip raised interruption");
  a_at_most_br: assert property (s_exec(OP_ADD_BRANCH_IF_AT_MOST_A) ##0 !instr.t[0] // RQ7
    |=> pc == $past(($signed(limit_sum) <= $signed(limit_max)) ? beta : pc + PC_STEP)) else $error("at most branch");
  a_above_br: assert property (s_exec(OP_ADD_BRANCH_IF_ABOVE_X) ##0 !instr.t[0] // RQ8
    |=> pc == $past(($signed(limit_sum) > $signed(limit_max)) ? beta : pc + PC_STEP)) else $error("above branch");
  a_odd_spec: assert property (st == S_EXEC && is_limit && instr.t[0] |=> spec_error && $stable(pc)) // RQ9
    else $error("odd pair not flagged");
  a_beta_base: assert property (st == S_EXEC && is_limit && !instr.t[0] && instr.m != 4'h0 && limit_take // RQ10
    |=> pc == $past(br[instr.m][23:0]) + {12'h000, instr.n}) else $error("base target wrong");
  a_push_quit: assert property (st == S_CNTRD && mem_resp.ack && push_bad // RQ14
    |=> st == S_IDLE && !mem_cmd.req && pc == $past(pc) + PC_STEP) else $error("abandon wrong");
  a_push_counts: assert property (s_counts_ok |=> mem_cmd.we && mem_cmd.addr == ea && mem_cmd.wdata == // RQ15
    $past({next_wc, next_sc})) else $error("count write wrong");
  a_push_ptr: assert property (st == S_DATWR && mem_resp.ack |=> mem_cmd.we && mem_cmd.addr == ea + PC_STEP // RQ16
    && mem_cmd.wdata == $past(tmp) + WORD_ONE) else $error("pointer update wrong");
  a_push_skip: assert property (st == S_PTRWR && mem_resp.ack |=> pc == $past(pc) + PC_SKIP && st == S_IDLE) // RQ17
    else $error("push skip wrong");
  a_dec_branch_nonzero_pc: assert property (s_exec(OP_DEC_BRANCH_NONZERO) // RQ18
    |=> pc == $past((xvr_read(instr.r) != WORD_ONE) ? ea : pc + PC_STEP)) else $error("dec branch wrong");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule

// file: testbench/lts_mem_model.sv
`timescale 1ns/1ps
module lts_mem_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire lts_pkg::lts_mem_cmd_t mem_cmd,
  output lts_pkg::lts_mem_resp_t mem_resp,
  input wire logic slow
);
  import lts_pkg::*;
  logic [31:0] mem [0:255];
  int wait_n;
  // ==========================================================
  // one ack pulse per request, read data scrambled outside the ack
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_resp <= '0;
      wait_n <= 0;
    end
    else if (mem_cmd.req && !mem_resp.ack && wait_n == 0)
    begin
      mem_resp.ack <= 1'b1;
      mem_resp.rdata <= mem_cmd.we ? ~mem_resp.rdata : mem[mem_cmd.addr[7:0]];
      if (mem_cmd.we)
        mem[mem_cmd.addr[7:0]] <= mem_cmd.wdata;
      wait_n <= slow ? 2 : 0;
    end
    else
    begin
      mem_resp.ack <= 1'b0;
      mem_resp.rdata <= ~mem_resp.rdata;
      if (mem_cmd.req && wait_n > 0)
        wait_n <= wait_n - 1;
    end
  end
endmodule

// file: testbench/test_loop_test_skip_branch_push_exec.sv
`timescale 1ns/1ps
module test_loop_test_skip_branch_push_exec;
  import lts_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  lts_mem_cmd_t mem_cmd;
  lts_mem_resp_t mem_resp;
  logic spec_error;
  logic [2:0] result_code;
  logic slow = 1'b0;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 39797;
  logic [31:0] rd, v, nv, mv, inc, lim, bv, ptr, cw;
  logic [23:0] pcv, ea, beta;
  logic [15:0] wc, sc;
  logic [11:0] n;
  logic [3:0] r, t, m;
  logic eq, tk;
  always #50 clk_sys = ~clk_sys;
  lts_exec_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_cmd(mem_cmd), .mem_resp(mem_resp), .spec_error(spec_error),
    .result_code(result_code));
  lts_mem_model mem_u (.clk_sys(clk_sys), .rst_n(rst_n), .mem_cmd(mem_cmd), .mem_resp(mem_resp), .slow(slow));
  // ==========================================================
  // reporting
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hang(input string s);
    mismatches++;
    $display("Error at %0t: %s timed out", $time, s);
    end_sim();
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string s);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask
  function automatic logic [2:0] rc(input logic [31:0] x);
    return {$signed(x) < 0, $signed(x) > 0, x == 32'h0};
  endfunction
  // ==========================================================
  // avalon master and engine control
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
      hang("bus");
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string s);
    bus(1'b0, a, 32'h0);
    chk_word(rd, exp, s);
  endtask
  task automatic run(input logic [31:0] instr, input logic [23:0] addr);
    int k;
    bus(1'b1, OFF_INSTR, instr);
    bus(1'b1, OFF_EA, {8'h00, addr});
    bus(1'b1, OFF_CTRL, 32'h1);
    k = 0;
    do
    begin
      bus(1'b0, OFF_STATUS, 32'h0);
      k++;
    end
    while (rd[0] !== 1'b0 && k < 40);
    if (k >= 40)
      hang("engine");
    slow <= !slow;
  endtask
  // ==========================================================
  // scenarios
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(OFF_PC, 32'h0, "pc reset");
    rdchk(OFF_STATUS, 32'h0, "status reset");
    rdchk(8'h44, 32'h0, "reg reset");
    rdchk(8'h20, 32'h0, "unmapped");
    $display("reset test done");
    for (int i = 0; i < 16; i++)
    begin
      r = 4'($random(seed));
      v = (i % 4 == 0) ? 32'h7FFF_FFFF : (i % 4 == 1) ? 32'h0 : $random(seed);
      nv = (i < 8) ? v + 32'h1 : v - 32'h1;
      mv = i[0] ? nv : $random(seed);
      ea = 24'h20 + 24'(i);
      pcv = 24'($random(seed));
      mem_u.mem[ea[7:0]] = mv;
      bus(1'b1, {2'b01, r, 2'b00}, v);
      bus(1'b1, OFF_PC, {8'h00, pcv});
      run({6'h20, i[3:2], r, 20'h0}, ea);
      eq = (nv == mv);
      tk = i[2] ? !eq : eq;
      rdchk({2'b01, r, 2'b00}, nv, "count reg");
      rdchk(OFF_PC, {8'h00, pcv + (tk ? PC_SKIP : PC_STEP)}, "skip pc");
      chk_word({29'h0, result_code}, {29'h0, rc(nv)}, "skip code");
      chk_word({31'h0, spec_error}, 32'h0, "skip interrupt");
    end
    $display("skip test done");
    for (int i = 0; i < 16; i++)
    begin
      t = 4'($random(seed));
      t[0] = 1'b0;
      r = i[3] ? 4'($random(seed)) : t ^ 4'h8;
      m = i[1] ? {i[3:2], 2'b01} : 4'h0;
      n = 12'($random(seed));
      inc = $random(seed);
      lim = $random(seed);
      v = $random(seed);
      bv = $random(seed);
      pcv = 24'($random(seed));
      if (i[0])
        lim = v + inc;
      bus(1'b1, {2'b01, t, 2'b00}, inc);
      bus(1'b1, {2'b01, t + 4'h1, 2'b00}, lim);
      bus(1'b1, {i[3] ? 2'b10 : 2'b01, r, 2'b00}, v);
      bus(1'b1, {2'b11, m, 2'b00}, bv);
      bus(1'b1, OFF_PC, {8'h00, pcv});
      run({6'h21, i[3:2], r, t, m, n}, 24'h0);
      nv = v + inc;
      tk = ($signed(nv) <= $signed(lim)) ^ i[2];
      beta = (m == 4'h0) ? pcv + {{12{n[11]}}, n} : bv[23:0] + {12'h000, n};
      rdchk({i[3] ? 2'b10 : 2'b01, r, 2'b00}, nv, "sum reg");
      rdchk(OFF_PC, {8'h00, tk ? beta : pcv + PC_STEP}, "branch pc");
      chk_word({29'h0, result_code}, {29'h0, rc(nv)}, "branch code");
    end
    bus(1'b1, 8'h58, 32'h5);
    bus(1'b1, OFF_PC, {8'h00, pcv});
    run({8'h84, 4'h6, 4'h3, 16'h0010}, 24'h0);
    chk_word({31'h0, spec_error}, 32'h1, "odd limit");
    rdchk(8'h58, 32'h5, "odd limit reg");
    rdchk(OFF_PC, {8'h00, pcv}, "odd limit pc");
    bus(1'b1, OFF_STATUS, 32'h10);
    @(posedge clk_sys);
    chk_word({31'h0, spec_error}, 32'h0, "spec clear");
    $display("branch test done");
    for (int i = 0; i < 3; i++)
    begin
      r = (i == 0) ? 4'h3 : (i == 1) ? 4'hC : 4'h5;
      v = (i == 2) ? 32'h1 : $random(seed);
      ea = 24'($random(seed));
      pcv = 24'($random(seed));
      bus(1'b1, {2'b10, r, 2'b00}, v);
      bus(1'b1, OFF_PC, {8'h00, pcv});
      run({8'h8F, r, 20'h0}, ea);
      nv = v - 32'h1;
      rdchk({2'b10, r, 2'b00}, nv, "loop reg");
      rdchk(OFF_PC, {8'h00, (nv != 0) ? ea : pcv + PC_STEP}, "loop pc");
    end
    $display("loop test done");
    for (int i = 0; i < 4; i++)
    begin
      r = 4'($random(seed));
      v = $random(seed);
      ea = 24'h10 + 24'(2 * i);
      cw = (i == 1) ? 32'h7FFF_0005 : (i == 2) ? 32'h0003_0000 : ($random(seed) & 32'h3FFF_3FFF) | 32'h1;
      ptr = (i == 0) ? 32'hFF00_00FF : {24'h0, 1'b1, 7'($random(seed))};
      pcv = 24'($random(seed));
      mem_u.mem[ea[7:0]] = cw;
      mem_u.mem[ea[7:0] + 8'h1] = ptr;
      mem_u.mem[ptr[7:0]] = ~v;
      wc = cw[31:16] + 16'h1;
      sc = cw[15:0] - 16'h1;
      tk = !wc[15] && !sc[15];
      bus(1'b1, {2'b01, r, 2'b00}, v);
      bus(1'b1, OFF_PC, {8'h00, pcv});
      run({8'h93, r, 20'h0}, ea);
      chk_word(mem_u.mem[ea[7:0]], tk ? {wc, sc} : cw, "counts");
      chk_word(mem_u.mem[ptr[7:0]], tk ? v : ~v, "pushed word");
      chk_word(mem_u.mem[ea[7:0] + 8'h1], tk ? ptr + 32'h1 : ptr, "pointer");
      rdchk(OFF_PC, {8'h00, pcv + (tk ? PC_SKIP : PC_STEP)}, "push pc");
      bus(1'b0, OFF_STATUS, 32'h0);
      chk_word({31'h0, rd[5]}, {31'h0, !tk}, "abandon flag");
      bus(1'b1, OFF_STATUS, 32'h20);
    end
    $display("push test done");
    end_sim();
  end
endmodule
